// file: src/lpm_pkg.sv
// Constants and types for the low-power mode controller.
package lpm_pkg;
  localparam logic [7:0] SFR_POWER_CTRL   = 8'h87;
  localparam logic [7:0] SFR_RING_CTRL    = 8'hc4;
  localparam logic [7:0] SFR_POWER_MODE   = 8'hc5;
  localparam logic [7:0] SFR_TIMED_ACCESS = 8'hc7;
  localparam logic [7:0] SFR_WATCHDOG     = 8'hd8;
  localparam logic [7:0] SFR_PROG_SIZE    = 8'hc2;
  localparam int         POWER_CONTROL_REG_IDLE_BIT    = 0;
  localparam int         POWER_CONTROL_REG_STOP_BIT    = 1;
  localparam int         RING_OSC_CONTROL_BGS_BIT     = 0;
  localparam int         RING_OSC_CONTROL_RING_SELECT_ON_WAKE_BIT    = 1;
  localparam int         RING_OSC_CONTROL_RING_ACTIVE_FLAG_BIT    = 2;
  localparam int         PMR_SUPPRESS_BIT = 2;
  localparam int         WATCHDOG_CONTROL_REG_IRQ_BIT    = 3;
  localparam logic [7:0] TA_KEY_FIRST     = 8'haa;
  localparam logic [7:0] TA_KEY_SECOND    = 8'h55;
  localparam logic [7:0] RING_OSC_CONTROL_WR_MASK     = 8'h03;
  localparam logic [7:0] PSIZE_WR_MASK    = 8'h07;
  localparam logic [7:0] WATCHDOG_CONTROL_REG_PROT_MASK  = 8'h4b;
  localparam logic [7:0] RING_OSC_CONTROL_PROT_MASK   = 8'h01;
  localparam logic [7:0] PSIZE_PROT_MASK  = 8'h07;
  localparam logic [7:0] POWER_CONTROL_REG_RESET       = 8'h00;
  localparam logic [7:0] RING_OSC_CONTROL_RESET       = 8'h00;
  localparam logic [7:0] PMR_RESET        = 8'h00;
  localparam logic [7:0] WATCHDOG_CONTROL_REG_RESET      = 8'h00;
  localparam logic [7:0] PSIZE_RESET      = 8'h07;
  localparam int         MCYCLE_CLKS      = 4;
  localparam int         ALE_HIGH_CLKS    = 2;
  localparam int         TA_WINDOW_MCYC   = 3;
  localparam int         TA_WINDOW_CLKS   = TA_WINDOW_MCYC * MCYCLE_CLKS;
  localparam int         RING_XTAL_CLOCKS = 65536;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lpm_sfr_req_t;

  typedef struct packed {
    logic any_irq;
    logic ext_irq;
    logic power_fail_irq;
    logic power_fail_rst;
  } lpm_wake_t;

  typedef enum logic [1:0] {
    TA_LOCKED = 2'b00,
    TA_ARMED  = 2'b01,
    TA_OPEN   = 2'b11
  } lpm_ta_state_t;

  typedef enum logic [1:0] {
    PWR_RUN       = 2'b00,
    PWR_IDLE      = 2'b01,
    PWR_STOP_PEND = 2'b11,
    PWR_STOP      = 2'b10
  } lpm_pwr_state_t;
endpackage : lpm_pkg

// file: src/lpm_ctrl.sv
// Low-power mode controller: idle, stop, ring start, timed access and strobe suppression.
`timescale 1ns/1ps
module lpm_ctrl
  import lpm_pkg::*;
#(
  parameter int unsigned RING_CLOCKS = RING_XTAL_CLOCKS
) (
  // Clock and reset.
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  // Special-function register port.
  input  wire lpm_sfr_req_t sfr_req_in,
  output logic [7:0]        sfr_rdata_out,
  // Core events.
  input  wire lpm_wake_t    wake_in,
  input  wire logic         instr_end_in,
  input  wire logic         ext_data_move_in,
  input  wire logic         wd_irq_set_in,
  // Clock and power controls.
  output logic              cpu_clk_en_out,
  output logic              periph_clk_en_out,
  output logic              xtal_osc_en_out,
  output logic              bandgap_en_out,
  output logic              ring_clk_sel_out,
  output logic              ale_out,
  // Protected settings.
  output logic [7:0]        watchdog_ctrl_out,
  output logic [2:0]        program_size_out
);

  localparam logic [16:0] RING_LAST   = 17'(RING_CLOCKS - 1);
  localparam logic [3:0]  WINDOW_LAST = 4'(TA_WINDOW_CLKS - 1);
  localparam logic [1:0]  ALE_PHASES  = 2'(ALE_HIGH_CLKS);

  function automatic logic sfr_hit(input lpm_sfr_req_t req, input logic [7:0] addr);
    sfr_hit = req.wr && (req.addr == addr);
  endfunction : sfr_hit

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] data,
                                       input logic [7:0] wmask);
    merge = (old & ~wmask) | (data & wmask);
  endfunction : merge

  // Reset synchroniser.
  logic rst_meta_q;
  logic rst_sync_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  logic wr_power_control_reg;
  logic wr_ring_osc_control;
  logic wr_pmr;
  logic wr_ta;
  logic wr_watchdog_control_reg;
  logic wr_psize;
  logic wr_prot;
  assign wr_power_control_reg  = sfr_hit(sfr_req_in, SFR_POWER_CTRL);
  assign wr_ring_osc_control  = sfr_hit(sfr_req_in, SFR_RING_CTRL);
  assign wr_pmr   = sfr_hit(sfr_req_in, SFR_POWER_MODE);
  assign wr_ta    = sfr_hit(sfr_req_in, SFR_TIMED_ACCESS);
  assign wr_watchdog_control_reg = sfr_hit(sfr_req_in, SFR_WATCHDOG);
  assign wr_psize = sfr_hit(sfr_req_in, SFR_PROG_SIZE);
  assign wr_prot  = wr_watchdog_control_reg | wr_ring_osc_control | wr_psize;

  // Timed access sequencer.
  lpm_ta_state_t ta_q;
  lpm_ta_state_t ta_d;
  logic [3:0]    ta_cnt_q;
  logic [3:0]    ta_cnt_d;
  logic          ta_open;
  assign ta_open = (ta_q == TA_OPEN);

  always_comb begin
    ta_d     = ta_q;
    ta_cnt_d = ta_cnt_q;
    unique case (ta_q)
      TA_LOCKED: begin
        if (wr_ta && sfr_req_in.wdata == TA_KEY_FIRST) begin
          ta_d = TA_ARMED;
        end
      end
      TA_ARMED: begin
        if (wr_ta && sfr_req_in.wdata == TA_KEY_SECOND) begin
          ta_d     = TA_OPEN;
          ta_cnt_d = WINDOW_LAST;
        end else if (wr_ta && sfr_req_in.wdata == TA_KEY_FIRST) begin
          ta_d = TA_ARMED;
        end else if (sfr_req_in.wr) begin
          ta_d = TA_LOCKED;
        end
      end
      TA_OPEN: begin
        if (wr_prot) begin
          ta_d = TA_LOCKED;
        end else if (wr_ta) begin
          ta_d = (sfr_req_in.wdata == TA_KEY_FIRST) ? TA_ARMED : TA_LOCKED;
        end else if (ta_cnt_q == 4'h0) begin
          ta_d = TA_LOCKED;
        end else begin
          ta_cnt_d = ta_cnt_q - 4'h1;
        end
      end
      default: ta_d = TA_LOCKED;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      ta_q     <= TA_LOCKED;
      ta_cnt_q <= 4'h0;
    end else begin
      ta_q     <= ta_d;
      ta_cnt_q <= ta_cnt_d;
    end
  end

  // Settings registers.
  logic [7:0] power_control_reg_q;
  logic [7:0] power_control_reg_d;
  logic [7:0] ring_osc_control_q;
  logic [7:0] ring_osc_control_d;
  logic [7:0] pmr_q;
  logic [7:0] pmr_d;
  logic [7:0] watchdog_control_reg_q;
  logic [7:0] watchdog_control_reg_d;
  logic [7:0] psize_q;
  logic [7:0] psize_d;
  logic [7:0] wd_mask;
  logic [7:0] rc_mask;
  logic [7:0] ps_mask;

  always_comb begin
    // Protected bits are masked off unless the window is open.
    wd_mask = ta_open ? 8'hff : ~WATCHDOG_CONTROL_REG_PROT_MASK;
    rc_mask = RING_OSC_CONTROL_WR_MASK & (ta_open ? 8'hff : ~RING_OSC_CONTROL_PROT_MASK);
    ps_mask = PSIZE_WR_MASK & (ta_open ? 8'hff : ~PSIZE_PROT_MASK);
    power_control_reg_d  = wr_power_control_reg ? sfr_req_in.wdata : power_control_reg_q;
    pmr_d   = wr_pmr ? sfr_req_in.wdata : pmr_q;
    ring_osc_control_d  = wr_ring_osc_control ? merge(ring_osc_control_q, sfr_req_in.wdata, rc_mask) : ring_osc_control_q;
    watchdog_control_reg_d = wr_watchdog_control_reg ? merge(watchdog_control_reg_q, sfr_req_in.wdata, wd_mask) : watchdog_control_reg_q;
    psize_d = wr_psize ? merge(psize_q, sfr_req_in.wdata, ps_mask) : psize_q;
    // Hardware setting of the watchdog flag wins over a clearing write.
    if (wd_irq_set_in) begin
      watchdog_control_reg_d[WATCHDOG_CONTROL_REG_IRQ_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      power_control_reg_q  <= POWER_CONTROL_REG_RESET;
      ring_osc_control_q  <= RING_OSC_CONTROL_RESET;
      pmr_q   <= PMR_RESET;
      watchdog_control_reg_q <= WATCHDOG_CONTROL_REG_RESET;
      psize_q <= PSIZE_RESET;
    end else begin
      power_control_reg_q  <= power_control_reg_d;
      ring_osc_control_q  <= ring_osc_control_d;
      pmr_q   <= pmr_d;
      watchdog_control_reg_q <= watchdog_control_reg_d;
      psize_q <= psize_d;
    end
  end

  // Power state and ring oscillator hand-over.
  lpm_pwr_state_t pwr_q;
  lpm_pwr_state_t pwr_d;
  logic           ring_q;
  logic           ring_d;
  logic [16:0]    ring_cnt_q;
  logic [16:0]    ring_cnt_d;
  logic           stop_wake;

  // External interrupt always wakes from stop.
  // Power-fail events wake when the reference is kept.
  assign stop_wake = wake_in.ext_irq | (ring_osc_control_q[RING_OSC_CONTROL_BGS_BIT] &
                     (wake_in.power_fail_irq | wake_in.power_fail_rst));

  always_comb begin
    pwr_d      = pwr_q;
    ring_d     = ring_q;
    ring_cnt_d = ring_cnt_q;
    unique case (pwr_q)
      PWR_RUN: begin
        // Stop waits for the instruction end.
        if (wr_power_control_reg && sfr_req_in.wdata[POWER_CONTROL_REG_STOP_BIT]) begin
          pwr_d = instr_end_in ? PWR_STOP : PWR_STOP_PEND;
        end else if (wr_power_control_reg && sfr_req_in.wdata[POWER_CONTROL_REG_IDLE_BIT]) begin
          pwr_d = PWR_IDLE;
        end
      end
      PWR_IDLE: begin
        if (wake_in.any_irq) begin
          pwr_d = PWR_RUN;
        end
      end
      PWR_STOP_PEND: begin
        if (instr_end_in) begin
          pwr_d = PWR_STOP;
        end
      end
      PWR_STOP: begin
        if (stop_wake) begin
          pwr_d = PWR_RUN;
          // Ring select chooses the ring on exit.
          if (ring_osc_control_q[RING_OSC_CONTROL_RING_SELECT_ON_WAKE_BIT]) begin
            ring_d     = 1'b1;
            ring_cnt_d = RING_LAST;
          end
        end
      end
    endcase
    if (ring_q) begin
      // Switch to crystal after the count.
      if (ring_cnt_q == 17'h0) begin
        ring_d = 1'b0;
      end else begin
        ring_cnt_d = ring_cnt_q - 17'h1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      pwr_q      <= PWR_RUN;
      ring_q     <= 1'b0;
      ring_cnt_q <= 17'h0;
    end else begin
      pwr_q      <= pwr_d;
      ring_q     <= ring_d;
      ring_cnt_q <= ring_cnt_d;
    end
  end

  // Address latch strobe and read data.
  logic [1:0] phase_q;
  logic [1:0] phase_d;
  logic       ale_q;
  logic       ale_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       in_idle;
  logic       in_stop;
  assign in_idle = (pwr_q == PWR_IDLE);
  assign in_stop = (pwr_q == PWR_STOP);

  always_comb begin
    phase_d = phase_q + 2'h1;
    // Suppressed strobe only pulses on external moves.
    // Unsuppressed strobe runs at crystal over four.
    ale_d = (phase_d < ALE_PHASES) &
            (!pmr_q[PMR_SUPPRESS_BIT] | ext_data_move_in);
    rdata_d = rdata_q;
    if (sfr_req_in.rd) begin
      unique case (sfr_req_in.addr)
        SFR_POWER_CTRL:   rdata_d = {power_control_reg_q[7:2], in_stop, in_idle};
        // Ring flag reads the active source.
        SFR_RING_CTRL:    rdata_d = {5'h00, ring_q, ring_osc_control_q[1:0]};
        SFR_POWER_MODE:   rdata_d = pmr_q;
        SFR_WATCHDOG:     rdata_d = watchdog_control_reg_q;
        SFR_PROG_SIZE:    rdata_d = {5'h00, psize_q[2:0]};
        default:          rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      phase_q <= 2'h0;
      ale_q   <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      phase_q <= phase_d;
      ale_q   <= ale_d;
      rdata_q <= rdata_d;
    end
  end

  assign sfr_rdata_out     = rdata_q;
  // Core halts in idle while peripherals run.
  assign cpu_clk_en_out    = (pwr_q == PWR_RUN) | (pwr_q == PWR_STOP_PEND);
  assign periph_clk_en_out = !in_stop;
  assign xtal_osc_en_out   = !in_stop;
  // Keep bit only matters in stop.
  assign bandgap_en_out    = !in_stop | ring_osc_control_q[RING_OSC_CONTROL_BGS_BIT];
  assign ring_clk_sel_out  = ring_q;
  assign ale_out           = ale_q;
  assign watchdog_ctrl_out = watchdog_control_reg_q;
  assign program_size_out  = psize_q[2:0];

endmodule : lpm_ctrl

// file: test/lpm_ctrl_props.sv
// Port assertions for the low-power mode controller.
`timescale 1ns/1ps
module lpm_ctrl_props
  import lpm_pkg::*;
#(
  parameter int unsigned RING_CLOCKS = RING_XTAL_CLOCKS
) (
  // Clock and reset.
  input wire logic         clk_in,
  input wire logic         rst_n_in,
  // Requests and events.
  input wire lpm_sfr_req_t sfr_req_in,
  input wire lpm_wake_t    wake_in,
  input wire logic         instr_end_in,
  input wire logic         ext_data_move_in,
  input wire logic         wd_irq_set_in,
  // Outputs.
  input wire logic [7:0]   sfr_rdata_out,
  input wire logic         cpu_clk_en_out,
  input wire logic         periph_clk_en_out,
  input wire logic         xtal_osc_en_out,
  input wire logic         bandgap_en_out,
  input wire logic         ring_clk_sel_out,
  input wire logic         ale_out,
  input wire logic [7:0]   watchdog_ctrl_out,
  input wire logic [2:0]   program_size_out
);
  logic [31:0] ring_cnt_q;
  logic [31:0] ring_cnt_d;
  logic        stop_wake;
  assign stop_wake = wake_in.ext_irq | wake_in.power_fail_irq | wake_in.power_fail_rst;
  always_comb begin
    ring_cnt_d = ring_clk_sel_out ? ring_cnt_q + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ring_cnt_q <= 32'h0;
    end else begin
      ring_cnt_q <= ring_cnt_d;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_stop_gates_all: assert property (!periph_clk_en_out
    |-> !cpu_clk_en_out && !xtal_osc_en_out)
    else $error("stop leaves a clock running");
  a_stop_entry_now: assert property (sfr_req_in.wr && sfr_req_in.addr == SFR_POWER_CTRL
    && sfr_req_in.wdata[POWER_CONTROL_REG_STOP_BIT] && instr_end_in && cpu_clk_en_out |=> !periph_clk_en_out)
    else $error("stop not entered");
  a_stop_holds: assert property (!periph_clk_en_out && !stop_wake
    |=> !periph_clk_en_out)
    else $error("stop left without external wake");
  a_stop_ext_wake: assert property (!periph_clk_en_out && wake_in.ext_irq
    |=> periph_clk_en_out)
    else $error("external interrupt did not end stop");
  a_idle_any_wake: assert property (!cpu_clk_en_out && periph_clk_en_out && wake_in.any_irq
    |=> cpu_clk_en_out) else $error("interrupt did not end idle");
  a_bandgap_only_stop: assert property (!bandgap_en_out |-> !periph_clk_en_out)
    else $error("reference off outside stop");
  a_ring_after_stop: assert property ($rose(ring_clk_sel_out)
    |-> !$past(periph_clk_en_out))
    else $error("ring selected outside stop exit");
  a_ring_run_length: assert property ($fell(ring_clk_sel_out)
    |-> ring_cnt_q == RING_CLOCKS)
    else $error("ring period has wrong length");
  a_ale_pulse_width: assert property ($rose(ale_out) |=> ##1 !ale_out)
    else $error("strobe high too long");
  a_ale_ext_move: assert property (ext_data_move_in [*3]
    |-> ##[0:1] (ale_out || $past(ale_out)))
    else $error("no strobe during external move");
  a_size_guarded: assert property (!$stable(program_size_out)
    |-> $past(sfr_req_in.wr) && $past(sfr_req_in.addr) == SFR_PROG_SIZE)
    else $error("program size changed without write");
  a_ring_flag_read: assert property ($past(sfr_req_in.rd)
    && $past(sfr_req_in.addr) == SFR_RING_CTRL
    |-> sfr_rdata_out[RING_OSC_CONTROL_RING_ACTIVE_FLAG_BIT] == $past(ring_clk_sel_out))
    else $error("ring flag read back wrong");
  a_wdog_flag_set: assert property (wd_irq_set_in
    |=> watchdog_ctrl_out[WATCHDOG_CONTROL_REG_IRQ_BIT])
    else $error("watchdog flag not set by hardware");
endmodule : lpm_ctrl_props
bind lpm_ctrl lpm_ctrl_props #(.RING_CLOCKS(RING_CLOCKS)) lpm_ctrl_props_i (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .sfr_req_in(sfr_req_in), .wake_in(wake_in),
  .instr_end_in(instr_end_in), .ext_data_move_in(ext_data_move_in),
  .wd_irq_set_in(wd_irq_set_in), .sfr_rdata_out(sfr_rdata_out),
  .cpu_clk_en_out(cpu_clk_en_out), .periph_clk_en_out(periph_clk_en_out),
  .xtal_osc_en_out(xtal_osc_en_out), .bandgap_en_out(bandgap_en_out),
  .ring_clk_sel_out(ring_clk_sel_out), .ale_out(ale_out),
  .watchdog_ctrl_out(watchdog_ctrl_out), .program_size_out(program_size_out));

// file: test/lpm_ctrl_bench.sv
// Self-checking testbench for the low-power mode controller.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin n_errors++; \
  $display("BAD %s expected %h seen %h", nm, exp, got); end end
module lpm_ctrl_bench
  import lpm_pkg::*;
;
  logic         clk_in = 1'b0;
  logic         rst_n_in = 1'b0;
  lpm_sfr_req_t req = '0;
  lpm_wake_t    wake = '0;
  logic         instr_end = 1'b0;
  logic         ext_move = 1'b0;
  logic         wd_set = 1'b0;
  logic [7:0]   rdata;
  logic [7:0]   wdog;
  logic [2:0]   psize;
  logic         cpu_en, per_en, xtal_en, bg_en, ring_sel, ale;
  int           n_errors = 0;
  int           samples_checked = 0;
  int           cnt;
  always #20 clk_in = ~clk_in;
  lpm_ctrl #(.RING_CLOCKS(16)) lpm_ctrl_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .sfr_req_in(req), .sfr_rdata_out(rdata),
    .wake_in(wake), .instr_end_in(instr_end), .ext_data_move_in(ext_move),
    .wd_irq_set_in(wd_set), .cpu_clk_en_out(cpu_en), .periph_clk_en_out(per_en),
    .xtal_osc_en_out(xtal_en), .bandgap_en_out(bg_en), .ring_clk_sel_out(ring_sel), .ale_out(ale),
    .watchdog_ctrl_out(wdog), .program_size_out(psize));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ie = 1'b0);
    @(posedge clk_in);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    instr_end <= ie;
    @(posedge clk_in);
    req <= '0;
    instr_end <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_in);
    req <= '0;
    #1;
    `CHK("rdata", exp, rdata)
  endtask : rd
  task automatic unlock;
    wr(SFR_TIMED_ACCESS, TA_KEY_FIRST);
    wr(SFR_TIMED_ACCESS, TA_KEY_SECOND);
  endtask : unlock
  task automatic wpulse(input lpm_wake_t w);
    @(posedge clk_in);
    wake <= w;
    @(posedge clk_in);
    wake <= '0;
  endtask : wpulse
  task automatic ale_count(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge clk_in);
      #1;
      c += int'(ale);
    end
  endtask : ale_count
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (2000) @(posedge clk_in);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    tick(3);
    `CHK("psize", 3'h7, psize)
    rd(SFR_RING_CTRL, 8'h00);
    wr(SFR_WATCHDOG, 8'hff);
    tick(1);
    `CHK("wdog", 8'hb4, wdog)
    unlock();
    wr(SFR_WATCHDOG, 8'hff);
    tick(1);
    `CHK("wdog", 8'hff, wdog)
    wr(SFR_WATCHDOG, 8'h00);
    tick(1);
    `CHK("wdog", 8'h4b, wdog)
    unlock();
    tick(10);
    wr(SFR_PROG_SIZE, 8'h05);
    tick(1);
    `CHK("psize", 3'h5, psize)
    unlock();
    tick(11);
    wr(SFR_PROG_SIZE, 8'h00);
    tick(1);
    `CHK("psize", 3'h5, psize)
    wr(SFR_TIMED_ACCESS, TA_KEY_FIRST);
    wr(SFR_POWER_MODE, 8'h00);
    wr(SFR_TIMED_ACCESS, TA_KEY_SECOND);
    wr(SFR_RING_CTRL, 8'h03);
    rd(SFR_RING_CTRL, 8'h02);
    rd(SFR_TIMED_ACCESS, 8'h00);
    unlock();
    wr(SFR_PROG_SIZE, 8'h02);
    tick(1);
    `CHK("psize", 3'h2, psize)
    unlock();
    wr(SFR_RING_CTRL, 8'h03);
    rd(SFR_RING_CTRL, 8'h03);
    wr(SFR_POWER_CTRL, 8'h02, 1'b1);
    tick(1);
    `CHK("periph", 1'b0, per_en)
    `CHK("xtal", 1'b0, xtal_en)
    `CHK("bandgap", 1'b1, bg_en)
    wpulse(4'b1000);
    tick(2);
    `CHK("periph", 1'b0, per_en)
    wpulse(4'b0010);
    tick(1);
    `CHK("periph", 1'b1, per_en)
    `CHK("xtal", 1'b1, xtal_en)
    `CHK("ring", 1'b1, ring_sel)
    rd(SFR_RING_CTRL, 8'h07);
    tick(20);
    `CHK("ring", 1'b0, ring_sel)
    rd(SFR_RING_CTRL, 8'h03);
    unlock();
    wr(SFR_RING_CTRL, 8'h00);
    wr(SFR_POWER_CTRL, 8'h02);
    tick(1);
    `CHK("cpu", 1'b1, cpu_en)
    @(posedge clk_in);
    instr_end <= 1'b1;
    @(posedge clk_in);
    instr_end <= 1'b0;
    tick(1);
    `CHK("periph", 1'b0, per_en)
    `CHK("bandgap", 1'b0, bg_en)
    wpulse(4'b0010);
    tick(1);
    `CHK("periph", 1'b0, per_en)
    wpulse(4'b0100);
    tick(1);
    `CHK("periph", 1'b1, per_en)
    `CHK("ring", 1'b0, ring_sel)
    wr(SFR_POWER_CTRL, 8'h01);
    tick(1);
    `CHK("cpu", 1'b0, cpu_en)
    `CHK("periph", 1'b1, per_en)
    `CHK("bandgap", 1'b1, bg_en)
    wpulse(4'b1000);
    tick(1);
    `CHK("cpu", 1'b1, cpu_en)
    ale_count(16, cnt);
    `CHK("ale", 8, cnt)
    wr(SFR_POWER_MODE, 8'h04);
    ale_count(16, cnt);
    `CHK("ale", 0, cnt)
    @(posedge clk_in);
    ext_move <= 1'b1;
    ale_count(16, cnt);
    `CHK("ale", 8, cnt)
    @(posedge clk_in);
    ext_move <= 1'b0;
    unlock();
    wr(SFR_WATCHDOG, 8'h00);
    tick(1);
    `CHK("wdog", 8'h00, wdog)
    @(posedge clk_in);
    wd_set <= 1'b1;
    @(posedge clk_in);
    wd_set <= 1'b0;
    tick(1);
    `CHK("wdog", 8'h08, wdog)
    tally_and_finish();
  end
endmodule : lpm_ctrl_bench
